// [rtl/pbtl_trigger.sv]
// breakpoint trigger logic with its ahb-lite register slave
`timescale 1ns/1ps
`include "pbtl_map.svh"

module pbtl_trigger (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // processor program counter
    input  wire logic [31:0] pc,
    input  wire logic        pc_valid,
    // processor local bus
    input  wire logic [31:0] bus_addr,
    input  wire logic [31:0] bus_data,
    input  wire logic        bus_valid,
    // trigger responses
    output logic [3:0]       debug_data_out,
    output logic             debug_data_valid,
    output logic             halt_request,
    output logic             debug_interrupt,
    // interrupt
    output logic             irq
);

    // ============================================================
    // state
    typedef struct packed {
        logic [31:0]         pc_breakpoint_address;
        logic [31:0]         pc_breakpoint_mask;
        logic [31:0]         trigger_definition;
        logic [31:0]         data_breakpoint_value;
        logic [31:0]         data_breakpoint_mask;
        logic [31:0]         address_range_low;
        logic [31:0]         address_range_high;
        logic [1:0]          breakpoint_trigger_status;
        pbtl_pkg::pbtl_level_t level;
        logic [1:0]          int_status;
        logic [1:0]          int_mask;
        logic                wr_pend;
        logic [7:0]          wr_ofs;
        logic [31:0]         rdata;
        logic [3:0]          dcode;
        logic                dcode_valid;
        logic                halt;
        logic                dbg_irq;
    } pbtl_state_t;

    pbtl_state_t r;
    pbtl_state_t next_r;

    logic        fire1;
    logic        fire2;
    logic        take;
    logic        complete;
    logic [1:0]  done_level;
    logic [1:0]  rsp_sel;
    logic        en1;
    logic        en2;

    // ============================================================
    // register read mux
    function automatic logic [31:0] read_mux(input pbtl_state_t s,
                                             input logic [7:0] ofs);
        logic [31:0] v;
        v = `PBTL_RST_WORD;
        case (ofs)
            `PBTL_OFS_PC_ADDR:    v = s.pc_breakpoint_address;
            `PBTL_OFS_PC_MASK:    v = s.pc_breakpoint_mask;
            `PBTL_OFS_TRIG_DEF:   v = s.trigger_definition;
            `PBTL_OFS_DATA_VALUE: v = s.data_breakpoint_value;
            `PBTL_OFS_DATA_MASK:  v = s.data_breakpoint_mask;
            `PBTL_OFS_RANGE_LOW:  v = s.address_range_low;
            `PBTL_OFS_RANGE_HIGH: v = s.address_range_high;
            `PBTL_OFS_CFG_STATUS: begin
                v[1:0] = s.breakpoint_trigger_status;
                v[2]   = (s.level == pbtl_pkg::PBTL_LVL_SECOND);
            end
            `PBTL_OFS_INT_STATUS: v[1:0] = s.int_status;
            `PBTL_OFS_INT_MASK:   v[1:0] = s.int_mask;
            default:              v = `PBTL_RST_WORD;
        endcase
        return v;
    endfunction

    // ============================================================
    // the two trigger levels
    pbtl_level_eval u_level1 (
        .cfg                   (r.trigger_definition[`PBTL_HALF_W-1:0]),
        .combine_or            (r.trigger_definition[`PBTL_L1_COMBINE]),
        .pc                    (pc),
        .pc_valid              (pc_valid),
        .pc_breakpoint_address (r.pc_breakpoint_address),
        .pc_breakpoint_mask    (r.pc_breakpoint_mask),
        .bus_addr              (bus_addr),
        .bus_data              (bus_data),
        .bus_valid             (bus_valid),
        .data_breakpoint_value (r.data_breakpoint_value),
        .data_breakpoint_mask  (r.data_breakpoint_mask),
        .address_range_low     (r.address_range_low),
        .address_range_high    (r.address_range_high),
        .fire                  (fire1)
    );

    pbtl_level_eval u_level2 (
        .cfg                   (r.trigger_definition[`PBTL_HALF_HI:`PBTL_HALF_LO]),
        .combine_or            (r.trigger_definition[`PBTL_L2_COMBINE]),
        .pc                    (pc),
        .pc_valid              (pc_valid),
        .pc_breakpoint_address (r.pc_breakpoint_address),
        .pc_breakpoint_mask    (r.pc_breakpoint_mask),
        .bus_addr              (bus_addr),
        .bus_data              (bus_data),
        .bus_valid             (bus_valid),
        .data_breakpoint_value (r.data_breakpoint_value),
        .data_breakpoint_mask  (r.data_breakpoint_mask),
        .address_range_low     (r.address_range_low),
        .address_range_high    (r.address_range_high),
        .fire                  (fire2)
    );

    // ============================================================
    // next state
    always_comb begin
        next_r = r;
        take   = hsel && hready && htrans[1];
        en1    = r.trigger_definition[`PBTL_LV_ENABLE];
        en2    = r.trigger_definition[`PBTL_HALF_LO + `PBTL_LV_ENABLE];
        rsp_sel = r.trigger_definition[`PBTL_RSP_HI:`PBTL_RSP_LO];
        complete   = 1'b0;
        done_level = `PBTL_RST_2B;

        // --- bus data phase: writes land one cycle after address
        if (r.wr_pend) begin
            case (r.wr_ofs)
                `PBTL_OFS_PC_ADDR:
                    next_r.pc_breakpoint_address = hwdata;
                `PBTL_OFS_PC_MASK:
                    next_r.pc_breakpoint_mask = hwdata;
                `PBTL_OFS_TRIG_DEF: begin
                    next_r.trigger_definition = hwdata;
                    next_r.breakpoint_trigger_status = `PBTL_RST_2B;
                    next_r.level = pbtl_pkg::PBTL_LVL_FIRST;
                end
                `PBTL_OFS_DATA_VALUE:
                    next_r.data_breakpoint_value = hwdata;
                `PBTL_OFS_DATA_MASK:
                    next_r.data_breakpoint_mask = hwdata;
                `PBTL_OFS_RANGE_LOW:
                    next_r.address_range_low = hwdata;
                `PBTL_OFS_RANGE_HIGH:
                    next_r.address_range_high = hwdata;
                `PBTL_OFS_INT_STATUS:
                    next_r.int_status = r.int_status & ~hwdata[1:0];
                `PBTL_OFS_INT_MASK:
                    next_r.int_mask = hwdata[1:0];
                default: begin
                end
            endcase
        end
        next_r.wr_pend = take && hwrite;
        next_r.wr_ofs  = haddr[7:0];

        // --- trigger sequencing; only the registered config is used,
        // so a half-loaded set can still fire until software disables
        // the levels first
        next_r.dcode_valid = 1'b0;
        next_r.halt        = 1'b0;
        next_r.dbg_irq     = 1'b0;
        case (r.level)
            pbtl_pkg::PBTL_LVL_FIRST: begin
                if (fire1 && en2) begin
                    next_r.level = pbtl_pkg::PBTL_LVL_SECOND;
                    next_r.breakpoint_trigger_status[`PBTL_ST_LEVEL1] = 1'b1;
                    next_r.int_status[`PBTL_ST_LEVEL1] = 1'b1;
                end else if (fire1) begin
                    complete   = 1'b1;
                    done_level = `PBTL_LVL_CODE_1;
                end else if (!en1 && fire2) begin
                    complete   = 1'b1;
                    done_level = `PBTL_LVL_CODE_2;
                end
            end
            pbtl_pkg::PBTL_LVL_SECOND: begin
                if (!en2) begin
                    next_r.level = pbtl_pkg::PBTL_LVL_FIRST;
                end else if (fire2) begin
                    complete     = 1'b1;
                    done_level   = `PBTL_LVL_CODE_2;
                    next_r.level = pbtl_pkg::PBTL_LVL_FIRST;
                end
            end
            default: begin
                next_r.level = pbtl_pkg::PBTL_LVL_FIRST;
            end
        endcase

        // a hit in the same cycle as a clear is kept
        if (complete) begin
            next_r.breakpoint_trigger_status[`PBTL_ST_DONE] = 1'b1;
            next_r.int_status[`PBTL_ST_DONE] = 1'b1;
            next_r.dcode       = {done_level, rsp_sel};
            next_r.dcode_valid = 1'b1;
            case (rsp_sel)
                `PBTL_RSP_HALT: next_r.halt    = 1'b1;
                `PBTL_RSP_IRQ:  next_r.dbg_irq = 1'b1;
                default: begin
                end
            endcase
        end

        // read data taken from the post-write view, so a read that
        // follows a write back to back sees the new value
        next_r.rdata = r.rdata;
        if (take && !hwrite) begin
            next_r.rdata = read_mux(next_r, haddr[7:0]);
        end
    end

    // ============================================================
    // registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r.pc_breakpoint_address     <= `PBTL_RST_WORD;
            r.pc_breakpoint_mask        <= `PBTL_RST_WORD;
            r.trigger_definition        <= `PBTL_RST_WORD;
            r.data_breakpoint_value     <= `PBTL_RST_WORD;
            r.data_breakpoint_mask      <= `PBTL_RST_WORD;
            r.address_range_low         <= `PBTL_RST_WORD;
            r.address_range_high        <= `PBTL_RST_WORD;
            r.breakpoint_trigger_status <= `PBTL_RST_2B;
            r.level                     <= pbtl_pkg::PBTL_LVL_FIRST;
            r.int_status                <= `PBTL_RST_2B;
            r.int_mask                  <= `PBTL_RST_2B;
            r.wr_pend                   <= 1'b0;
            r.wr_ofs                    <= 8'h00;
            r.rdata                     <= `PBTL_RST_WORD;
            r.dcode                     <= 4'h0;
            r.dcode_valid               <= 1'b0;
            r.halt                      <= 1'b0;
            r.dbg_irq                   <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    // ============================================================
    // outputs
    assign hreadyout        = 1'b1;
    assign hresp            = 1'b0;
    assign hrdata           = r.rdata;
    assign debug_data_out   = r.dcode;
    assign debug_data_valid = r.dcode_valid;
    assign halt_request     = r.halt;
    assign debug_interrupt  = r.dbg_irq;
    assign irq              = |(r.int_status & r.int_mask);

endmodule

// [rtl/pbtl_map.svh]
// register offsets, field positions and reset values of the trigger block
`ifndef PBTL_MAP_SVH
`define PBTL_MAP_SVH

// ============================================================
// register byte offsets
`define PBTL_OFS_PC_ADDR     8'h00
`define PBTL_OFS_PC_MASK     8'h04
`define PBTL_OFS_TRIG_DEF    8'h08
`define PBTL_OFS_DATA_VALUE  8'h0C
`define PBTL_OFS_DATA_MASK   8'h10
`define PBTL_OFS_RANGE_LOW   8'h14
`define PBTL_OFS_RANGE_HIGH  8'h18
`define PBTL_OFS_CFG_STATUS  8'h1C
`define PBTL_OFS_INT_STATUS  8'h20
`define PBTL_OFS_INT_MASK    8'h24

// ============================================================
// trigger definition: whole-register fields
`define PBTL_RSP_HI          31
`define PBTL_RSP_LO          30
`define PBTL_L2_COMBINE      15
`define PBTL_L1_COMBINE      14
`define PBTL_HALF_HI         31
`define PBTL_HALF_LO         16
`define PBTL_HALF_W          16

// ============================================================
// trigger definition: positions within one level half
`define PBTL_LV_ENABLE       13
`define PBTL_LV_DATA_LONG    12
`define PBTL_LV_DATA_LOWW    11
`define PBTL_LV_DATA_HIGHW   10
`define PBTL_LV_DATA_LL      9
`define PBTL_LV_DATA_LM      8
`define PBTL_LV_DATA_UM      7
`define PBTL_LV_DATA_UU      6
`define PBTL_LV_DATA_INV     5
`define PBTL_LV_ADDR_INV     4
`define PBTL_LV_ADDR_RANGE   3
`define PBTL_LV_ADDR_LOW     2
`define PBTL_LV_PC_EN        1
`define PBTL_LV_PC_INV       0

// ============================================================
// response codes and status layout
`define PBTL_RSP_REPORT      2'b00
`define PBTL_RSP_HALT        2'b01
`define PBTL_RSP_IRQ         2'b10
`define PBTL_LVL_CODE_1      2'b01
`define PBTL_LVL_CODE_2      2'b10
`define PBTL_ST_LEVEL1       0
`define PBTL_ST_DONE         1
`define PBTL_RST_WORD        32'h0000_0000
`define PBTL_RST_2B          2'b00

`endif

// [rtl/pbtl_pkg.sv]
// types shared by the breakpoint trigger block
package pbtl_pkg;

    typedef enum logic {
        PBTL_LVL_FIRST,
        PBTL_LVL_SECOND
    } pbtl_level_t;

endpackage

// [rtl/pbtl_level_eval.sv]
// one trigger level: pc, address range and data conditions combined
`timescale 1ns/1ps
`include "pbtl_map.svh"

module pbtl_level_eval (
    // level configuration
    input  wire logic [15:0] cfg,
    input  wire logic        combine_or,
    // program counter side
    input  wire logic [31:0] pc,
    input  wire logic        pc_valid,
    input  wire logic [31:0] pc_breakpoint_address,
    input  wire logic [31:0] pc_breakpoint_mask,
    // local bus side
    input  wire logic [31:0] bus_addr,
    input  wire logic [31:0] bus_data,
    input  wire logic        bus_valid,
    input  wire logic [31:0] data_breakpoint_value,
    input  wire logic [31:0] data_breakpoint_mask,
    input  wire logic [31:0] address_range_low,
    input  wire logic [31:0] address_range_high,
    // result
    output logic             fire
);
    logic        pc_en;
    logic        pc_cond;
    logic        addr_en;
    logic        addr_cond;
    logic        data_en;
    logic        data_cond;
    logic [31:0] lane;
    logic        in_range;
    logic        ad_term;

    always_comb begin
        // masked bits drop out of the pc compare
        pc_en   = cfg[`PBTL_LV_PC_EN];
        pc_cond = pc_valid && (((pc ^ pc_breakpoint_address)
                  & ~pc_breakpoint_mask) == `PBTL_RST_WORD);
        pc_cond = pc_cond ^ cfg[`PBTL_LV_PC_INV];
        pc_cond = pc_cond && pc_valid;

        in_range  = (bus_addr >= address_range_low)
                    && (bus_addr <= address_range_high);
        addr_en   = cfg[`PBTL_LV_ADDR_INV] | cfg[`PBTL_LV_ADDR_RANGE]
                    | cfg[`PBTL_LV_ADDR_LOW];
        addr_cond = bus_valid && (
            (cfg[`PBTL_LV_ADDR_LOW] && (bus_addr == address_range_low))
            || (cfg[`PBTL_LV_ADDR_RANGE] && in_range)
            || (cfg[`PBTL_LV_ADDR_INV] && !in_range));

        // byte lanes that take part in the data compare
        lane = {32{cfg[`PBTL_LV_DATA_LONG]}};
        lane[15:0]  = lane[15:0]  | {16{cfg[`PBTL_LV_DATA_LOWW]}};
        lane[31:16] = lane[31:16] | {16{cfg[`PBTL_LV_DATA_HIGHW]}};
        lane[7:0]   = lane[7:0]   | {8{cfg[`PBTL_LV_DATA_LL]}};
        lane[15:8]  = lane[15:8]  | {8{cfg[`PBTL_LV_DATA_LM]}};
        lane[23:16] = lane[23:16] | {8{cfg[`PBTL_LV_DATA_UM]}};
        lane[31:24] = lane[31:24] | {8{cfg[`PBTL_LV_DATA_UU]}};
        data_en   = |cfg[`PBTL_LV_DATA_LONG:`PBTL_LV_DATA_UU];
        data_cond = (((bus_data ^ data_breakpoint_value)
                    & ~data_breakpoint_mask & lane) == `PBTL_RST_WORD);
        data_cond = bus_valid
                    && (data_cond ^ cfg[`PBTL_LV_DATA_INV]);

        // a disabled condition is a don't-care inside the and-term
        ad_term = (addr_en || data_en)
                  && (!addr_en || addr_cond)
                  && (!data_en || data_cond);
        if (combine_or) begin
            fire = (pc_en && pc_cond) || ad_term;
        end else begin
            fire = (pc_en || addr_en || data_en)
                   && (!pc_en || pc_cond)
                   && (!addr_en || addr_cond)
                   && (!data_en || data_cond);
        end
        fire = fire && cfg[`PBTL_LV_ENABLE];
    end

endmodule

// [testbench/pbtl_trigger_props.sv]
// concurrent checks on the trigger block's response and interrupt outputs
`timescale 1ns/1ps
`include "pbtl_map.svh"

module pbtl_trigger_props (
    // clock and reset
    input wire logic       hclk,
    input wire logic       hresetn,
    // processor side
    input wire logic       pc_valid,
    input wire logic       bus_valid,
    // responses
    input wire logic [3:0] debug_data_out,
    input wire logic       debug_data_valid,
    input wire logic       halt_request,
    input wire logic       debug_interrupt,
    input wire logic       irq
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ============================================================
    // response selection and reporting
    property p_halt;
        halt_request |-> debug_data_valid &&
            debug_data_out[1:0] == `PBTL_RSP_HALT;
    endproperty
    a_halt: assert property (p_halt) else $error("halt without code");
    property p_halt_on_code;
        debug_data_valid && debug_data_out[1:0] == `PBTL_RSP_HALT
            |-> halt_request;
    endproperty
    a_halt_on_code: assert property (p_halt_on_code)
        else $error("halt code without halt");
    property p_dint;
        debug_interrupt |-> debug_data_valid &&
            debug_data_out[1:0] == `PBTL_RSP_IRQ;
    endproperty
    a_dint: assert property (p_dint) else $error("irq without code");
    property p_dint_on_code;
        debug_data_valid && debug_data_out[1:0] == `PBTL_RSP_IRQ
            |-> debug_interrupt;
    endproperty
    a_dint_on_code: assert property (p_dint_on_code)
        else $error("irq code without debug interrupt");
    property p_one_action;
        !(halt_request && debug_interrupt);
    endproperty
    a_one_action: assert property (p_one_action)
        else $error("halt and interrupt together");
    property p_level_code;
        debug_data_valid |-> debug_data_out[3:2] inside {2'b01, 2'b10};
    endproperty
    a_level_code: assert property (p_level_code)
        else $error("completion without level code");
    property p_hold;
        !debug_data_valid |-> $stable(debug_data_out);
    endproperty
    a_hold: assert property (p_hold) else $error("report moved");

    // ============================================================
    // causes and reset
    property p_cause;
        debug_data_valid |-> $past(pc_valid || bus_valid);
    endproperty
    a_cause: assert property (p_cause) else $error("trigger from nothing");
    property p_reset;
        $rose(hresetn) |-> !debug_data_valid && !irq ##1 !debug_data_valid;
    endproperty
    a_reset: assert property (p_reset) else $error("fired after reset");

    c_halt: cover property (halt_request);
    c_dint: cover property (debug_interrupt);
    c_level2: cover property (debug_data_valid && debug_data_out[3:2] == 2'b10);
    c_irq: cover property ($rose(irq));
endmodule

bind pbtl_trigger pbtl_trigger_props i_props (
    .hclk             (hclk),
    .hresetn          (hresetn),
    .pc_valid         (pc_valid),
    .bus_valid        (bus_valid),
    .debug_data_out   (debug_data_out),
    .debug_data_valid (debug_data_valid),
    .halt_request     (halt_request),
    .debug_interrupt  (debug_interrupt),
    .irq              (irq)
);

// [testbench/pbtl_core_model.sv]
// processor core stand-in driving program counter and local bus
`timescale 1ns/1ps

module pbtl_core_model (
    // clock
    input  wire logic   hclk,
    // program counter
    output logic [31:0] pc,
    output logic        pc_valid,
    // local bus
    output logic [31:0] bus_addr,
    output logic [31:0] bus_data,
    output logic        bus_valid
);
    initial begin
        pc        = 32'h5a5a_5a5a;
        pc_valid  = 1'b0;
        bus_addr  = 32'ha5a5_a5a5;
        bus_data  = 32'h3c3c_3c3c;
        bus_valid = 1'b0;
    end

    // one qualified cycle; idle lines show the inverse, never a stale copy
    task automatic step(input logic [31:0] p, input logic pv,
                        input logic [31:0] d, input logic bv);
        pc        <= p;
        pc_valid  <= pv;
        bus_addr  <= p;
        bus_data  <= d;
        bus_valid <= bv;
        @(posedge hclk);
        pc        <= ~p;
        pc_valid  <= 1'b0;
        bus_addr  <= ~p;
        bus_data  <= ~d;
        bus_valid <= 1'b0;
    endtask
endmodule

// [testbench/tb_pc_breakpoint_trigger_logic.sv]
// self-checking bench for the breakpoint trigger block
`timescale 1ns/1ps
`include "pbtl_map.svh"

module tb_pc_breakpoint_trigger_logic;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic        hreadyout, hresp, pc_valid, bus_valid, irq;
    logic [31:0] hrdata, pc, bus_addr, bus_data;
    logic        debug_data_valid, halt_request, debug_interrupt;
    logic [3:0]  debug_data_out;
    logic [5:0]  last_resp = 6'h00;
    logic [31:0] rd_val, va, vm, vp, lane_m;
    logic [1:0]  rsp_sel;
    int          n_done = 0;
    int          n_fail = 0;
    int          cmp_count = 0;
    integer      seed = 32'h1f19;

    always #4 hclk = ~hclk;

    pbtl_core_model i_core (.hclk(hclk), .pc(pc), .pc_valid(pc_valid),
        .bus_addr(bus_addr), .bus_data(bus_data), .bus_valid(bus_valid));

    pbtl_trigger i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .pc(pc), .pc_valid(pc_valid),
        .bus_addr(bus_addr), .bus_data(bus_data), .bus_valid(bus_valid),
        .debug_data_out(debug_data_out), .debug_data_valid(debug_data_valid),
        .halt_request(halt_request), .debug_interrupt(debug_interrupt),
        .irq(irq));

    // completions are caught here so a one-cycle pulse is never missed
    always @(posedge hclk) begin
        if (debug_data_valid === 1'b1) begin
            n_done    <= n_done + 1;
            last_resp <= {debug_data_out, halt_request, debug_interrupt};
        end
    end

    // ============================================================
    // compare, bus and trigger tasks
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_trig(input logic [6:0] got, input logic [6:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd_val = hrdata;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0000_0000);
        chk_reg(rd_val, exp);
    endtask
    task automatic chk_irq(input logic e);
        @(negedge hclk);
        chk_reg({31'h0, irq}, {31'h0, e});
        @(posedge hclk);
    endtask
    task automatic trig(input logic [31:0] p, input logic pv, input logic [31:0] d,
                        input logic bv, input logic fire, input logic [5:0] exp);
        int n0;
        n0 = n_done;
        i_core.step(p, pv, d, bv);
        repeat (2) @(posedge hclk);
        chk_trig({n_done != n0, (n_done != n0) ? last_resp : 6'h00},
                 {fire, fire ? exp : 6'h00});
    endtask
    function automatic logic [5:0] f_resp(input logic [1:0] lvl,
                                          input logic [1:0] t);
        return {lvl, t, t == `PBTL_RSP_HALT, t == `PBTL_RSP_IRQ};
    endfunction

    // ============================================================
    // verdict and watchdog
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #100000;
        n_fail++;
        report_and_stop();
    end

    // ============================================================
    // scenarios
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int o = 0; o <= 'h24; o += 4) rd_chk(o[7:0], 32'h0);
        ahb(1'b1, `PBTL_OFS_CFG_STATUS, 32'hffff_ffff);
        ahb(1'b1, 8'h30, 32'hffff_ffff);
        rd_chk(`PBTL_OFS_CFG_STATUS, 32'h0);
        rd_chk(8'h30, 32'h0);
        trig(32'h0, 1'b1, 32'h0, 1'b1, 1'b0, 6'h00);
        // every response code, random region, masked and inverted
        for (int i = 0; i < 16; i++) begin
            rsp_sel = i[1:0];
            va = $random(seed);
            vm = $random(seed) & 32'h00ff_00f0;
            vp = va ^ (vm & $random(seed)) ^ (i[3] ? 32'h0 : 32'h0000_0100);
            ahb(1'b1, `PBTL_OFS_TRIG_DEF, 32'h0);
            ahb(1'b1, `PBTL_OFS_PC_ADDR, va);
            ahb(1'b1, `PBTL_OFS_PC_MASK, vm);
            rd_chk(`PBTL_OFS_PC_MASK, vm);
            ahb(1'b1, `PBTL_OFS_TRIG_DEF,
                {rsp_sel, 14'h0000, 15'h1001, i[2]});
            trig(vp, 1'b1, ~vp, 1'b0, i[3] ^ i[2], f_resp(2'b01, rsp_sel));
        end
        ahb(1'b1, `PBTL_OFS_TRIG_DEF, 32'h0);
        ahb(1'b1, `PBTL_OFS_PC_MASK, 32'h0);
        ahb(1'b1, `PBTL_OFS_TRIG_DEF, 32'h0000_2000);
        trig(va, 1'b1, va, 1'b1, 1'b0, 6'h00);
        ahb(1'b1, `PBTL_OFS_TRIG_DEF, 32'h0000_0002);
        trig(va, 1'b1, va, 1'b1, 1'b0, 6'h00);
        // data lanes, combine form and data invert
        ahb(1'b1, `PBTL_OFS_DATA_VALUE, va);
        ahb(1'b1, `PBTL_OFS_DATA_MASK, 32'h0);
        for (int k = 0; k < 16; k++) begin
            lane_m = (k[1:0] == 0) ? 32'hffff_ffff : (k[1:0] == 1) ?
                32'h0000_ffff : (k[1:0] == 2) ? 32'hffff_0000 : 32'h0000_00ff;
            ahb(1'b1, `PBTL_OFS_TRIG_DEF, 32'h0000_2002 | (k[2] << 14) |
                (32'h1 << (12 - k[1:0])) | (k[3] << 5));
            trig(va, 1'b0, va ^ ~lane_m, 1'b1, k[2] & ~k[3], f_resp(2'b01, 2'b00));
            trig(va, 1'b0, va ^ (lane_m & -lane_m), 1'b1, k[2] & k[3], f_resp(2'b01, 2'b00));
        end
        // address condition alone; data left out of the and-term
        ahb(1'b1, `PBTL_OFS_TRIG_DEF, 32'h0);
        ahb(1'b1, `PBTL_OFS_RANGE_LOW, va);
        ahb(1'b1, `PBTL_OFS_RANGE_HIGH, va);
        ahb(1'b1, `PBTL_OFS_TRIG_DEF, 32'h0000_2004);
        trig(va, 1'b0, ~va, 1'b1, 1'b1, f_resp(2'b01, 2'b00));
        trig(~va, 1'b0, ~va, 1'b1, 1'b0, 6'h00);
        // two levels, status, interrupt mask and clear
        ahb(1'b1, `PBTL_OFS_TRIG_DEF, 32'h0);
        ahb(1'b1, `PBTL_OFS_INT_STATUS, 32'h3);
        ahb(1'b1, `PBTL_OFS_INT_MASK, 32'h2);
        ahb(1'b1, `PBTL_OFS_PC_ADDR, va);
        for (int t = 1; t < 3; t++) begin
            ahb(1'b1, `PBTL_OFS_TRIG_DEF, {t[1:0], 14'h3002, 16'ha002});
            trig(va, 1'b0, va, 1'b1, 1'b0, 6'h00);
            trig(va, 1'b1, ~va, 1'b0, 1'b0, 6'h00);
            rd_chk(`PBTL_OFS_CFG_STATUS, 32'h5);
            chk_irq(1'b0);
            trig(va ^ 32'h1, 1'b0, va, 1'b1, 1'b1, f_resp(2'b10, t[1:0]));
            rd_chk(`PBTL_OFS_CFG_STATUS, 32'h3);
            chk_irq(1'b1);
            ahb(1'b1, `PBTL_OFS_INT_MASK, 32'h0);
            chk_irq(1'b0);
            ahb(1'b1, `PBTL_OFS_INT_MASK, 32'h2);
            ahb(1'b1, `PBTL_OFS_INT_STATUS, 32'h3);
            chk_irq(1'b0);
            ahb(1'b1, `PBTL_OFS_TRIG_DEF, {t[1:0], 14'h3002, 16'ha002});
            rd_chk(`PBTL_OFS_CFG_STATUS, 32'h0);
        end
        report_and_stop();
    end
endmodule
